// file: design/virtual_message_interrupt_params.svh
`ifndef VIRTUAL_MESSAGE_INTERRUPT_PARAMS_SVH
`define VIRTUAL_MESSAGE_INTERRUPT_PARAMS_SVH
`define VIRTUAL_MESSAGE_INTERRUPT_LIST_LPI_MIN      32'h00002000
`define VIRTUAL_MESSAGE_INTERRUPT_NO_DOORBELL       32'h000003FF
`define VIRTUAL_MESSAGE_INTERRUPT_LPI_MIN           32'h00002000
`define VIRTUAL_MESSAGE_INTERRUPT_IMPL_WIDTH        5'h04
`define VIRTUAL_MESSAGE_INTERRUPT_NUM_ENTRIES       16
`define VIRTUAL_MESSAGE_INTERRUPT_NUM_VIRQ          16
`define VIRTUAL_MESSAGE_INTERRUPT_FEATURE_LATER     4'h3
`define VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL          4'h0
`define VIRTUAL_MESSAGE_INTERRUPT_OFF_PENDBASE      4'h4
`define VIRTUAL_MESSAGE_INTERRUPT_OFF_STATUS        4'h8
`define VIRTUAL_MESSAGE_INTERRUPT_OFF_TYPE2         4'hC
`define VIRTUAL_MESSAGE_INTERRUPT_CTRL_RESET        32'h00000010
`endif

// file: design/virtual_message_interrupt_pkg.sv
package virtual_message_interrupt_pkg;
  typedef enum logic [1:0] {
    VIRTUAL_MESSAGE_INTERRUPT_IDLE = 2'b00,
    VIRTUAL_MESSAGE_INTERRUPT_LOOK = 2'b01,
    VIRTUAL_MESSAGE_INTERRUPT_DONE = 2'b10
  } virtual_message_interrupt_state_t;
  typedef struct packed {
    logic        is_virtual;
    logic [15:0] element;
    logic [31:0] element_width_value;
    logic [31:0] doorbell;
  } virtual_message_interrupt_entry_t;
endpackage

// file: design/virtual_message_interrupt_table.sv
`timescale 1ns/1ps
`include "virtual_message_interrupt_params.svh"
module virtual_message_interrupt_table (
  input  wire logic                     clk,
  input  wire logic                     wr_en,
  input  wire logic [3:0]               wr_idx,
  input  wire virtual_message_interrupt_pkg::virtual_message_interrupt_entry_t    wr_data,
  input  wire logic [3:0]               rd_idx,
  output virtual_message_interrupt_pkg::virtual_message_interrupt_entry_t         rd_data
);
  import virtual_message_interrupt_pkg::*;
  // ==========================================
  // Translation entry store
  virtual_message_interrupt_entry_t mem [0:`VIRTUAL_MESSAGE_INTERRUPT_NUM_ENTRIES-1];
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule

// file: design/virtual_message_interrupt_inject.sv
// The register offsets and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
`include "virtual_message_interrupt_params.svh"
module virtual_message_interrupt_inject (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic                   map_valid,
  input  wire logic [3:0]             map_event,
  input  wire logic                   map_is_virtual,
  input  wire logic [15:0]            map_element,
  input  wire logic [31:0]            map_vid,
  input  wire logic [31:0]            map_doorbell,
  input  wire logic [31:0]            map_pt_addr,
  input  wire logic                   event_valid,
  input  wire logic [3:0]             event_id,
  output logic                        event_ready,
  output logic                        cmd_error,
  input  wire logic                   list_valid,
  input  wire logic [31:0]            list_vid,
  input  wire logic [7:0]             list_prio,
  input  wire logic                   el3_present,
  input  wire logic                   cpu_secure,
  input  wire logic [3:0]             cpu_feature_irqctl_field,
  input  wire logic                   softint_deact,
  output logic                        virq_valid,
  output logic [31:0]                 virq_id,
  output logic                        virq_from_list,
  output logic                        doorbell_valid,
  output logic [31:0]                 doorbell_id,
  output logic [7:0]                  end_of_irq_counter
);
  import virtual_message_interrupt_pkg::*;

  // ==========================================
  // Reset release
  logic rst_s1_reg;
  logic rst_n_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  // ==========================================
  // Registers
  // ctrl: [0] secure_el2_enable, [1] virtual_softint_deact_count_en,
  // [4:2] configured width-1, [8] pending_table_init_flag
  logic [31:0] ctrl_reg;
  logic        pend_valid_reg;
  logic [31:0] vpe_pending_base_reg;
  logic [15:0] sched_element_reg;
  logic        pending_at_deschedule;
  logic [4:0]  cfg_width;
  logic        sched_match;
  logic        any_pending;
  logic        pend_write;
  logic        map_ok;
  assign cfg_width  = {2'b00, ctrl_reg[4:2]} + 5'h01;
  assign pend_write = avs_write && !avs_waitrequest && avs_address == `VIRTUAL_MESSAGE_INTERRUPT_OFF_PENDBASE;

  // One-cycle answer: wait only on the first cycle of a request
  logic ack_reg;
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl_reg <= `VIRTUAL_MESSAGE_INTERRUPT_CTRL_RESET;
    end else if (avs_write && !avs_waitrequest && avs_address == `VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL) begin
      ctrl_reg <= avs_writedata;
    end
  end

  // Pending base: [31] valid, [15:0] element, address in writedata low bits
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pend_valid_reg       <= 1'b0;
      vpe_pending_base_reg <= 32'h00000000;
      sched_element_reg    <= 16'h0000;
    end else if (pend_write) begin
      pend_valid_reg       <= avs_writedata[31];
      vpe_pending_base_reg <= {1'b0, avs_writedata[30:0]};
      sched_element_reg    <= avs_writedata[15:0];
    end
  end

  // ==========================================
  // Element table: pending table address per element
  logic [31:0] elem_addr [0:`VIRTUAL_MESSAGE_INTERRUPT_NUM_ENTRIES-1];
  logic [`VIRTUAL_MESSAGE_INTERRUPT_NUM_VIRQ-1:0] pend_bits;
  genvar g;
  generate
    for (g = 0; g < `VIRTUAL_MESSAGE_INTERRUPT_NUM_ENTRIES; g++) begin : g_elem
      always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          elem_addr[g] <= 32'h00000000;
        end else if (map_ok && map_element[3:0] == g) begin
          elem_addr[g] <= map_pt_addr;
        end
      end
    end
  endgenerate
  assign sched_match = pend_valid_reg &&
                       vpe_pending_base_reg == elem_addr[sched_element_reg[3:0]];
  assign any_pending = |pend_bits;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pending_at_deschedule <= 1'b0;
    end else if (pend_write && pend_valid_reg && !avs_writedata[31]) begin
      pending_at_deschedule <= any_pending;
    end
  end

  // ==========================================
  // Mapping with index checks
  logic        map_bad;
  virtual_message_interrupt_entry_t map_entry;
  virtual_message_interrupt_entry_t cur;
  logic        db_bad;
  assign db_bad  = map_doorbell != `VIRTUAL_MESSAGE_INTERRUPT_NO_DOORBELL && map_doorbell < `VIRTUAL_MESSAGE_INTERRUPT_LPI_MIN;
  assign map_bad = (map_element >> cfg_width) != 16'h0000 ||
                   (map_element >> `VIRTUAL_MESSAGE_INTERRUPT_IMPL_WIDTH) != 16'h0000 || db_bad;
  assign map_ok  = map_valid && !map_bad;
  assign map_entry = '{is_virtual: map_is_virtual, element: map_element,
                       element_width_value: map_vid, doorbell: map_doorbell};

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      cmd_error <= 1'b0;
    end else begin
      cmd_error <= map_valid && map_bad;
    end
  end

  // ==========================================
  // Event lookup
  virtual_message_interrupt_state_t state_reg;
  logic [3:0]  ev_reg;
  virtual_message_interrupt_table u_table (
    .clk     (clk),
    .wr_en   (map_ok),
    .wr_idx  (map_event),
    .wr_data (map_entry),
    .rd_idx  (ev_reg),
    .rd_data (cur)
  );
  assign event_ready = state_reg == VIRTUAL_MESSAGE_INTERRUPT_IDLE;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= VIRTUAL_MESSAGE_INTERRUPT_IDLE;
      ev_reg    <= 4'h0;
    end else begin
      case (state_reg)
        VIRTUAL_MESSAGE_INTERRUPT_IDLE: begin
          if (event_valid) begin
            ev_reg    <= event_id;
            state_reg <= VIRTUAL_MESSAGE_INTERRUPT_LOOK;
          end
        end
        VIRTUAL_MESSAGE_INTERRUPT_LOOK: state_reg <= VIRTUAL_MESSAGE_INTERRUPT_DONE;
        VIRTUAL_MESSAGE_INTERRUPT_DONE: state_reg <= VIRTUAL_MESSAGE_INTERRUPT_IDLE;
        default:   state_reg <= VIRTUAL_MESSAGE_INTERRUPT_IDLE;
      endcase
    end
  end

  logic resident;
  logic hit;
  logic [3:0] best_idx;
  logic       best_found;
  logic       direct_ok;
  logic       list_lpi;
  logic       list_pick;
  logic       virq_take;
  assign resident = sched_match && cur.element == sched_element_reg;
  assign hit      = state_reg == VIRTUAL_MESSAGE_INTERRUPT_DONE && cur.is_virtual;

  // Pending bits for resident element, indexed by low vid bits
  generate
    for (g = 0; g < `VIRTUAL_MESSAGE_INTERRUPT_NUM_VIRQ; g++) begin : g_pend
      always_ff @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
          pend_bits[g] <= 1'b0;
        end else if (hit && resident && cur.element_width_value[3:0] == g) begin
          pend_bits[g] <= 1'b1; // set wins over clear
        end else if (pend_write || (virq_take && !list_pick && best_idx == g)) begin
          pend_bits[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      doorbell_valid <= 1'b0;
      doorbell_id    <= 32'h00000000;
    end else begin
      doorbell_valid <= hit && !resident && cur.doorbell != `VIRTUAL_MESSAGE_INTERRUPT_NO_DOORBELL;
      doorbell_id    <= cur.doorbell;
    end
  end

  // ==========================================
  // Selection: lowest index is highest priority
  always_comb begin
    best_idx   = 4'h0;
    best_found = 1'b0;
    for (int i = `VIRTUAL_MESSAGE_INTERRUPT_NUM_VIRQ - 1; i >= 0; i--) begin
      if (pend_bits[i]) begin
        best_idx   = 4'(i);
        best_found = 1'b1;
      end
    end
  end
  // Secure with el3_present withholds direct ones whatever secure_el2_enable says
  assign direct_ok = best_found && sched_match && !(el3_present && cpu_secure);
  assign list_lpi  = list_valid && list_vid >= `VIRTUAL_MESSAGE_INTERRUPT_LIST_LPI_MIN;
  // List entry ranks against a direct one by priority; index maps to 8-bit priority
  assign list_pick = list_valid && (!direct_ok || list_prio < {best_idx, 4'h0});
  assign virq_take = virq_valid;

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      virq_valid     <= 1'b0;
      virq_id        <= 32'h00000000;
      virq_from_list <= 1'b0;
    end else begin
      virq_valid     <= !virq_valid && (list_pick || direct_ok);
      virq_id        <= list_pick ? list_vid : {`VIRTUAL_MESSAGE_INTERRUPT_LPI_MIN + {28'h0, best_idx}};
      virq_from_list <= list_pick && !list_lpi;
    end
  end

  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      end_of_irq_counter <= 8'h00;
    end else if (softint_deact && ctrl_reg[1]) begin
      end_of_irq_counter <= end_of_irq_counter + 8'h01;
    end
  end

  // ==========================================
  // Read mux; type2 [4:0] width-1, [5] width valid, [7:6] affinity ones
  logic later_rev;
  assign later_rev = cpu_feature_irqctl_field == `VIRTUAL_MESSAGE_INTERRUPT_FEATURE_LATER;
  always_ff @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read) begin
      case (avs_address)
        `VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL:     avs_readdata <= ctrl_reg;
        `VIRTUAL_MESSAGE_INTERRUPT_OFF_PENDBASE: avs_readdata <= {pend_valid_reg, vpe_pending_base_reg[30:0]};
        `VIRTUAL_MESSAGE_INTERRUPT_OFF_STATUS:   avs_readdata <= {29'h0, later_rev, sched_match,
                                             pending_at_deschedule};
        `VIRTUAL_MESSAGE_INTERRUPT_OFF_TYPE2:    avs_readdata <= {24'h0, 2'b11, 1'b1,
                                             `VIRTUAL_MESSAGE_INTERRUPT_IMPL_WIDTH - 5'h01};
        default:            avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // Checks
  property p_doorbell;
    @(posedge clk) disable iff (!rst_n_reg)
      (hit && !resident && cur.doorbell != `VIRTUAL_MESSAGE_INTERRUPT_NO_DOORBELL) |=> doorbell_valid;
  endproperty
  a_doorbell: assert property (p_doorbell) else $error("doorbell missing");
  property p_no_secure;
    @(posedge clk) disable iff (!rst_n_reg)
      (el3_present && cpu_secure && !list_valid) |=> !virq_valid;
  endproperty
  a_no_secure: assert property (p_no_secure) else $error("secure delivery");
  property p_cmd_err;
    @(posedge clk) disable iff (!rst_n_reg)
      (map_valid && (map_element >> cfg_width) != 16'h0000) |=> cmd_error;
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("no command error");
  property p_none_db;
    @(posedge clk) disable iff (!rst_n_reg)
      doorbell_valid |-> doorbell_id != `VIRTUAL_MESSAGE_INTERRUPT_NO_DOORBELL;
  endproperty
  a_none_db: assert property (p_none_db) else $error("null doorbell sent");

  // ==========================================
  // Lookup, bus, delivery, deschedule flag and index width checks
  sequence s_event_taken;
    event_valid && event_ready;
  endsequence
  sequence s_lookup_walk;
    ##1 (state_reg == VIRTUAL_MESSAGE_INTERRUPT_LOOK) ##1 (state_reg == VIRTUAL_MESSAGE_INTERRUPT_DONE) ##1 (state_reg == VIRTUAL_MESSAGE_INTERRUPT_IDLE);
  endsequence
  property p_lookup;
    @(posedge clk) disable iff (!rst_n_reg)
      s_event_taken |-> s_lookup_walk;
  endproperty
  a_lookup: assert property (p_lookup) else $error("event lookup out of step");

  property p_bus_once;
    @(posedge clk) disable iff (!rst_n_reg)
      ((avs_read || avs_write) && avs_waitrequest) |=> ack_reg;
  endproperty
  a_bus_once: assert property (p_bus_once) else $error("bus answer late");

  property p_direct_fwd;
    @(posedge clk) disable iff (!rst_n_reg)
      (direct_ok && !list_valid && !virq_valid) |=>
        (virq_valid && virq_id == `VIRTUAL_MESSAGE_INTERRUPT_LPI_MIN + {28'h0, $past(best_idx)});
  endproperty
  a_direct_fwd: assert property (p_direct_fwd) else $error("direct interrupt not sent");

  property p_list_fwd;
    @(posedge clk) disable iff (!rst_n_reg)
      (list_valid && !direct_ok && !virq_valid) |=> (virq_valid && virq_id == $past(list_vid));
  endproperty
  a_list_fwd: assert property (p_list_fwd) else $error("list entry not sent");

  property p_pend_last;
    @(posedge clk) disable iff (!rst_n_reg)
      (pend_write && pend_valid_reg && !avs_writedata[31] && any_pending) |=>
        pending_at_deschedule;
  endproperty
  a_pend_last: assert property (p_pend_last) else $error("deschedule flag missing");

  property p_impl_err;
    @(posedge clk) disable iff (!rst_n_reg)
      (map_valid && (map_element >> `VIRTUAL_MESSAGE_INTERRUPT_IMPL_WIDTH) != 16'h0000) |=> cmd_error;
  endproperty
  a_impl_err: assert property (p_impl_err) else $error("wide index accepted");
endmodule

// file: sim/virtual_message_interrupt_its_model.sv
`timescale 1ns/1ps
// ==========================================
// Translation service stand-in
module virtual_message_interrupt_its_model (
  input  wire logic        clk,
  input  wire logic        event_ready,
  output logic             map_valid,
  output logic [3:0]       map_event,
  output logic             map_is_virtual,
  output logic [15:0]      map_element,
  output logic [31:0]      map_vid,
  output logic [31:0]      map_doorbell,
  output logic [31:0]      map_pt_addr,
  output logic             event_valid,
  output logic [3:0]       event_id
);
  initial begin
    map_valid = 1'b0;
    map_event = 4'h0;
    map_is_virtual = 1'b0;
    map_element = 16'h0000;
    map_vid = 32'h00000000;
    map_doorbell = 32'h00000000;
    map_pt_addr = 32'h00000000;
    event_valid = 1'b0;
    event_id = 4'h0;
  end
  // Doorbell is 1023 or inside the message range, never else
  // Element width only narrowed, init flag never touched
  task map_entry(input logic [3:0] ev, input logic [15:0] el, input logic [31:0] element_width_value,
                 input logic [31:0] db, input logic [31:0] pt);
    @(posedge clk);
    map_valid <= 1'b1;
    map_event <= ev;
    map_is_virtual <= 1'b1;
    map_element <= el;
    map_vid <= element_width_value;
    map_doorbell <= db;
    map_pt_addr <= pt;
    @(posedge clk);
    // Released data lines except map_event and map_is_virtual flip so stale data never looks valid
    map_valid <= 1'b0;
    map_element <= ~el;
    map_vid <= ~element_width_value;
    map_doorbell <= ~db;
    map_pt_addr <= ~pt;
  endtask
  task send_event(input logic [3:0] ev);
    @(posedge clk);
    event_valid <= 1'b1;
    event_id <= ev;
    @(posedge clk);
    while (event_ready !== 1'b1) @(posedge clk);
    event_valid <= 1'b0;
    event_id <= ~ev;
  endtask
endmodule

// file: sim/virtual_message_interrupt_inject_bench.sv
`timescale 1ns/1ps
`include "virtual_message_interrupt_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("Error at %0t ns: got %h expected %h", $time, g, e); end end
module virtual_message_interrupt_inject_bench;
  logic        clk = 1'b0, rstn, avs_read, avs_write, avs_waitrequest, map_valid;
  logic        map_is_virtual, event_valid, event_ready, cmd_error, list_valid;
  logic        el3_present, cpu_secure, softint_deact, virq_valid, virq_from_list;
  logic        doorbell_valid;
  logic [3:0]  avs_address, map_event, event_id, cpu_feature_irqctl_field;
  logic [15:0] map_element;
  logic [31:0] avs_writedata, avs_readdata, map_vid, map_doorbell, map_pt_addr;
  logic [31:0] list_vid, virq_id, doorbell_id, rd;
  logic [7:0]  list_prio, end_of_irq_counter;
  int          errors = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  virtual_message_interrupt_inject i_dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .map_valid, .map_event, .map_is_virtual, .map_element,
    .map_vid, .map_doorbell, .map_pt_addr, .event_valid, .event_id, .event_ready, .cmd_error,
    .list_valid, .list_vid, .list_prio, .el3_present, .cpu_secure, .cpu_feature_irqctl_field,
    .softint_deact, .virq_valid, .virq_id, .virq_from_list, .doorbell_valid, .doorbell_id,
    .end_of_irq_counter);
  virtual_message_interrupt_its_model i_its (.clk, .event_ready, .map_valid, .map_event, .map_is_virtual,
    .map_element, .map_vid, .map_doorbell, .map_pt_addr, .event_valid, .event_id);

  // ==========================================
  // Bus and watch tasks
  task report_and_stop;
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_write <= 1'b1;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
    avs_writedata <= ~d;
  endtask
  task bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    avs_read <= 1'b1;
    avs_address <= a;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // Pulses are short, so every cycle of the window is looked at
  task watch(input int sel, input logic want, input logic [31:0] id);
    logic seen;
    logic hit;
    logic [31:0] got;
    seen = 1'b0;
    got = 32'h00000000;
    repeat (30) begin
      @(posedge clk);
      #1 hit = (sel == 0) ? virq_valid : (sel == 1) ? doorbell_valid : cmd_error;
      if (!seen && hit === 1'b1) begin
        seen = 1'b1;
        got = (sel == 0) ? virq_id : (sel == 1) ? doorbell_id : id;
      end
    end
    `CHK(seen, want)
    if (want) `CHK(got, id)
  endtask
  task pulse_deact;
    @(posedge clk);
    softint_deact <= 1'b1;
    @(posedge clk);
    softint_deact <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask

  // ==========================================
  // Tests
  initial begin
    rstn = 1'b0;
    {avs_read, avs_write, list_valid, cpu_secure, softint_deact} = 5'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    list_vid = 32'h00000000;
    list_prio = 8'h00;
    el3_present = 1'b1;
    cpu_feature_irqctl_field = `VIRTUAL_MESSAGE_INTERRUPT_FEATURE_LATER;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    bus_read(`VIRTUAL_MESSAGE_INTERRUPT_OFF_TYPE2, rd);
    `CHK(rd[7:0], {2'b11, 1'b1, (`VIRTUAL_MESSAGE_INTERRUPT_IMPL_WIDTH - 5'h01)})
    bus_read(`VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL, rd);
    `CHK(rd, `VIRTUAL_MESSAGE_INTERRUPT_CTRL_RESET)
    bus_read(`VIRTUAL_MESSAGE_INTERRUPT_OFF_STATUS, rd);
    `CHK(rd[2:0], 3'b100)
    bus_read(4'h2, rd);
    `CHK(rd, 32'h00000000)
    cpu_feature_irqctl_field <= 4'h1;
    bus_read(`VIRTUAL_MESSAGE_INTERRUPT_OFF_STATUS, rd);
    `CHK(rd[2], 1'b0)
    i_its.map_entry(4'h1, 16'h0002, 32'h00002005, 32'h00002100, 32'h00010002);
    i_its.map_entry(4'h3, 16'h0002, 32'h00002007, `VIRTUAL_MESSAGE_INTERRUPT_NO_DOORBELL, 32'h00010002);
    i_its.send_event(4'h3);
    watch(1, 1'b0, 32'h0);
    i_its.send_event(4'h1);
    watch(1, 1'b1, 32'h00002100);
    fork
      i_its.map_entry(4'h5, 16'h0010, 32'h00002006, 32'h00002100, 32'h00010010);
      watch(2, 1'b1, 32'h0);
    join
    bus_write(`VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL, 32'h00000004);
    fork
      i_its.map_entry(4'h6, 16'h0004, 32'h00002006, 32'h00002100, 32'h00010004);
      watch(2, 1'b1, 32'h0);
    join
    bus_write(`VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL, `VIRTUAL_MESSAGE_INTERRUPT_CTRL_RESET);
    bus_write(`VIRTUAL_MESSAGE_INTERRUPT_OFF_PENDBASE, 32'h80010002);
    bus_read(`VIRTUAL_MESSAGE_INTERRUPT_OFF_STATUS, rd);
    `CHK(rd[1], 1'b1)
    i_its.send_event(4'h1);
    watch(0, 1'b1, 32'h00002005);
    @(posedge clk);
    cpu_secure <= 1'b1;
    i_its.send_event(4'h1);
    watch(0, 1'b0, 32'h0);
    bus_write(`VIRTUAL_MESSAGE_INTERRUPT_OFF_PENDBASE, 32'h00000000);
    bus_read(`VIRTUAL_MESSAGE_INTERRUPT_OFF_STATUS, rd);
    `CHK(rd[0], 1'b1)
    bus_write(`VIRTUAL_MESSAGE_INTERRUPT_OFF_PENDBASE, 32'h80010002);
    el3_present <= 1'b0;
    i_its.send_event(4'h1);
    watch(0, 1'b1, 32'h00002005);
    @(posedge clk);
    el3_present <= 1'b1;
    i_its.send_event(4'h1);
    repeat (5) @(posedge clk);
    cpu_secure <= 1'b0;
    list_valid <= 1'b1;
    list_prio <= 8'hFF;
    list_vid <= 32'h00002001;
    watch(0, 1'b1, 32'h00002005);
    repeat (4) @(posedge clk);
    watch(0, 1'b1, 32'h00002001);
    `CHK(virq_from_list, 1'b0)
    list_vid <= 32'h00000020;
    repeat (2) @(posedge clk);
    #1 `CHK(virq_from_list, 1'b1)
    list_valid <= 1'b0;
    bus_write(`VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL, `VIRTUAL_MESSAGE_INTERRUPT_CTRL_RESET | 32'h00000002);
    pulse_deact;
    `CHK(end_of_irq_counter, 8'h01)
    bus_write(`VIRTUAL_MESSAGE_INTERRUPT_OFF_CTRL, `VIRTUAL_MESSAGE_INTERRUPT_CTRL_RESET);
    pulse_deact;
    `CHK(end_of_irq_counter, 8'h01)
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(end_of_irq_counter, 8'h00)
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    bus_read(`VIRTUAL_MESSAGE_INTERRUPT_OFF_STATUS, rd);
    `CHK(rd[1:0], 2'b00)
    report_and_stop;
  end

  // Whole sequence needs a few hundred cycles
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
endmodule
